// *** health_pkg.sv ***
// constants for the health data readout block
package health_pkg;

	// task-file register addresses
	localparam logic [2:0] TF_ADDR_DATA       = 3'h0;
	localparam logic [2:0] TF_ADDR_FEATURES   = 3'h1;
	localparam logic [2:0] TF_ADDR_CYL_LOW    = 3'h4;
	localparam logic [2:0] TF_ADDR_CYL_HIGH   = 3'h5;
	localparam logic [2:0] TF_ADDR_DRIVE_SEL  = 3'h6;
	localparam logic [2:0] TF_ADDR_CMD_STATUS = 3'h7;

	// command and key values
	localparam logic [7:0] CMD_HEALTH      = 8'hB0;
	localparam logic [7:0] FEAT_READ_DATA  = 8'hD0;
	localparam logic [7:0] KEY_CYL_LOW     = 8'h4F;
	localparam logic [7:0] KEY_CYL_HIGH    = 8'hC2;

	// error register bit positions
	localparam int ERR_UNC_BIT   = 6;
	localparam int ERR_ID_NOT_FOUND_FLAG_BIT  = 4;
	localparam int ERR_ABORTED_FLAG_BIT  = 2;

	// status register bit positions
	localparam int STS_BUSY_BIT  = 7;
	localparam int STS_READY_BIT = 6;
	localparam int STS_FAULT_BIT = 5;
	localparam int STS_DRQ_BIT   = 3;
	localparam int STS_ERR_BIT   = 0;

	// structure layout, byte offsets
	localparam int STRUCT_BYTES       = 512;
	localparam int STRUCT_WORDS       = STRUCT_BYTES / 2;
	localparam int OFS_OFFLINE_STATUS = 362;
	localparam int OFS_SELFTEST       = 363;
	localparam int OFS_OFFLINE_TIME   = 364;
	localparam int OFS_OFFLINE_CAP    = 367;
	localparam int OFS_SMART_CAP      = 368;
	localparam int OFS_ERRLOG_CAP     = 370;
	localparam int OFS_POLL_SHORT     = 372;
	localparam int OFS_POLL_EXT       = 373;
	localparam int OFS_RSVD_FIRST     = 374;
	localparam int OFS_RSVD_LAST      = 385;
	localparam int OFS_CHECKSUM       = 511;

	// fixed content of the capability and polling bytes
	localparam logic [7:0]  OFFLINE_CAP_VAL  = 8'h19;
	localparam logic [15:0] SMART_CAP_VAL    = 16'h0003;
	localparam logic        ERRLOG_SUPPORTED = 1'b1;
	localparam logic [7:0]  POLL_SHORT_MIN   = 8'h02;
	localparam logic [7:0]  POLL_EXT_MIN     = 8'h0F;

	// off-line collection status codes
	localparam logic [6:0] OFFL_NEVER     = 7'h00;
	localparam logic [6:0] OFFL_DONE      = 7'h02;
	localparam logic [6:0] OFFL_SUSPENDED = 7'h04;
	localparam logic [6:0] OFFL_ABORT_HST = 7'h05;
	localparam logic [6:0] OFFL_ABORT_FTL = 7'h06;

	typedef enum logic [2:0] {
		REASON_NEVER     = 3'h0,
		REASON_DONE      = 3'h1,
		REASON_SUSPENDED = 3'h2,
		REASON_ABORT_HST = 3'h3,
		REASON_ABORT_FTL = 3'h4
	} offline_reason_t;

	// reset values
	localparam logic [7:0] ERROR_RESET     = 8'h00;
	localparam logic [7:0] DRIVE_SEL_RESET = 8'hA0;

endpackage

// *** offline_status_enc.sv ***
// encodes the off-line collection status byte
`timescale 1ns/1ps
module offline_status_enc
	import health_pkg::*;
(
	input  wire logic [2:0] reason,
	input  wire logic       auto_on,
	output logic      [7:0] status_byte
);

	logic [6:0] code;

	always_comb begin
		// only legal codes are ever produced
		// no reserved codes
		unique case (reason)
			REASON_NEVER:     code = OFFL_NEVER;
			REASON_DONE:      code = OFFL_DONE;
			REASON_SUSPENDED: code = OFFL_SUSPENDED;
			REASON_ABORT_HST: code = OFFL_ABORT_HST;
			REASON_ABORT_FTL: code = OFFL_ABORT_FTL;
			default:          code = OFFL_NEVER;
		endcase
		status_byte = {auto_on, code};
	end

endmodule

// *** checksum_acc.sv ***
// running byte sum and checksum of the structure
`timescale 1ns/1ps
module checksum_acc (
	input  wire logic       clk,
	input  wire logic       rst,
	input  wire logic       clear,
	input  wire logic       add_lo,
	input  wire logic       add_hi,
	input  wire logic [7:0] byte_lo,
	input  wire logic [7:0] byte_hi,
	output logic      [7:0] checksum
);

	logic [7:0] sum_q;
	logic [7:0] sum_d;

	always_comb begin
		sum_d = sum_q;
		if (add_lo) begin
			sum_d = 8'(sum_d + byte_lo);
		end
		if (add_hi) begin
			sum_d = 8'(sum_d + byte_hi);
		end
	end

	// overflow drops out by the 8-bit width
	always_ff @(posedge clk) begin
		if (rst || clear) begin
			sum_q <= 8'h00;
		end else begin
			sum_q <= sum_d;
		end
	end

	assign checksum = 8'(~sum_q + 8'h01);

endmodule

// *** health_data_readout.sv ***
// health data readout command block behind the task-file registers
`timescale 1ns/1ps
// Function
// - abort on unsupported command, disabled monitoring, or bad feature/key registers
// - set uncorrectable flag, error bit 6, when stored data cannot be corrected
// - set id-not-found flag, error bit 4, on missing sector id or checksum error
// - set aborted flag, error bit 2, for abort causes or incompletable action
// - error completion clears busy bit 7 and sets ready bit 6
// - error completion sets device-fault bit, status bit 5
// - error completion clears data-request bit, status bit 3
// - error status bit 0 set whenever any error register bit is set
// - device-select bit keeps naming the selected device in error outputs
// - success returns exactly 512 bytes; vendor bytes hold vendor content (this block leaves them at zero)
// - off-line status byte 362, self-test byte 363, seconds at 364-365
// - off-line capability 367, monitoring capability 368-369, error-log capability 370
// - error-log capability bit 0 means logging supported, bits 7-1 reserved
// - short self-test poll minutes in 372, extended in 373
// - reserved bytes 374 through 385 read as zero
// - fixed bytes never change; variable bytes may follow device state
// - off-line status 00h/80h never started, 02h/82h completed cleanly
// - 04h/84h suspended, 05h/85h host abort, 06h/86h fatal abort
// - reserved status codes never reported; vendor ranges left to vendor
// - byte 511 is two's complement of byte sum 0 to 510
module health_data_readout
	import health_pkg::*;
(
	input  wire logic        REF_CLK,
	input  wire logic        RST,
	input  wire logic        TF_WR,
	input  wire logic        TF_RD,
	input  wire logic [2:0]  TF_ADDR,
	input  wire logic [7:0]  TF_WDATA,
	output logic      [15:0] TF_RDATA,
	input  wire logic        CMD_SUPPORTED,
	input  wire logic        SMART_ENABLED,
	input  wire logic        DATA_UNCORRECTABLE,
	input  wire logic        ID_NOT_FOUND,
	input  wire logic [2:0]  OFFLINE_REASON,
	input  wire logic        OFFLINE_AUTO,
	input  wire logic [7:0]  SELFTEST_STATUS,
	input  wire logic [15:0] OFFLINE_SECONDS
);

	typedef enum logic [1:0] {
		ST_IDLE  = 2'b00,
		ST_CHECK = 2'b01,
		ST_SUM   = 2'b11,
		ST_XFER  = 2'b10
	} state_t;

	state_t      state_q;
	state_t      state_d;

	logic [7:0]  features_q;
	logic [7:0]  cyl_low_q;
	logic [7:0]  cyl_high_q;
	logic [7:0]  drive_sel_q;
	logic [7:0]  error_q;
	logic        busy_q;
	logic        fault_q;
	logic        drq_q;
	logic [7:0]  word_idx_q;
	logic [15:0] rdata_q;
	logic        cmd_ok_q;

	// snapshot of the variable bytes, held for one whole readout
	logic [7:0]  offl_snap_q;
	logic [7:0]  self_snap_q;
	logic [15:0] secs_snap_q;
	logic [7:0]  offl_byte;

	logic        cmd_write;
	logic        data_read;
	logic        keys_ok;
	logic        last_word;
	logic [7:0]  checksum;
	logic [7:0]  status_reg;
	logic [7:0]  pair_byte [2];
	logic        abort_cause;
	logic        fail_cause;
	logic        sum_done;
	logic        xfer_done;

	// a command is taken while idle or transferring, never while busy
	assign cmd_write = TF_WR && (TF_ADDR == TF_ADDR_CMD_STATUS) && !busy_q;
	// of the data reads, only those during the transfer move the word pointer
	assign data_read = TF_RD && (TF_ADDR == TF_ADDR_DATA) && (state_q == ST_XFER);
	// word 255 carries byte 510 and the checksum
	assign last_word = (word_idx_q == 8'(STRUCT_WORDS - 1));

	assign keys_ok = (features_q == FEAT_READ_DATA) && (cyl_low_q == KEY_CYL_LOW)
	              && (cyl_high_q == KEY_CYL_HIGH);

	// any abort cause ends the command before the stored data is looked at
	assign abort_cause = !(cmd_ok_q && CMD_SUPPORTED && SMART_ENABLED && keys_ok);
	// a legal request can still fail on the stored data itself
	assign fail_cause  = abort_cause || DATA_UNCORRECTABLE || ID_NOT_FOUND;
	assign sum_done    = (state_q == ST_SUM) && last_word;
	assign xfer_done   = data_read && last_word;

	offline_status_enc i_offline_status_enc (
		.reason      (OFFLINE_REASON),
		.auto_on     (OFFLINE_AUTO),
		.status_byte (offl_byte)
	);

	// structure bytes for the even and odd byte of the current word
	// vendor bytes are left at zero; a product fills them in this case
	generate
		for (genvar g = 0; g < 2; g++) begin : g_lane
			logic [8:0] idx;
			assign idx = {word_idx_q, 1'(g)};
			always_comb begin
				unique case (int'(idx))
					OFS_OFFLINE_STATUS:   pair_byte[g] = offl_snap_q;
					OFS_SELFTEST:         pair_byte[g] = self_snap_q;
					// low byte at the lower offset
					OFS_OFFLINE_TIME:     pair_byte[g] = secs_snap_q[7:0];
					OFS_OFFLINE_TIME + 1: pair_byte[g] = secs_snap_q[15:8];
					OFS_OFFLINE_CAP:      pair_byte[g] = OFFLINE_CAP_VAL;
					OFS_SMART_CAP:        pair_byte[g] = SMART_CAP_VAL[7:0];
					OFS_SMART_CAP + 1:    pair_byte[g] = SMART_CAP_VAL[15:8];
					OFS_ERRLOG_CAP:       pair_byte[g] = {7'h00, ERRLOG_SUPPORTED};
					OFS_POLL_SHORT:       pair_byte[g] = POLL_SHORT_MIN;
					OFS_POLL_EXT:         pair_byte[g] = POLL_EXT_MIN;
					OFS_CHECKSUM:         pair_byte[g] = checksum;
					// reserved and vendor bytes read zero
					default:              pair_byte[g] = 8'h00;
				endcase
			end
		end
	endgenerate

	// sums every byte but the checksum during the pass before transfer
	checksum_acc i_checksum_acc (
		.clk      (REF_CLK),
		.rst      (RST),
		.clear    (state_q == ST_CHECK),
		.add_lo   (state_q == ST_SUM),
		.add_hi   ((state_q == ST_SUM) && !last_word),
		.byte_lo  (pair_byte[0]),
		.byte_hi  (pair_byte[1]),
		.checksum (checksum)
	);

	// host-written task-file registers
	always_ff @(posedge REF_CLK) begin
		if (RST) begin
			features_q  <= 8'h00;
			cyl_low_q   <= 8'h00;
			cyl_high_q  <= 8'h00;
			drive_sel_q <= DRIVE_SEL_RESET;
		end else if (TF_WR && !busy_q) begin
			// writes while busy are dropped so the running command keeps its operands
			unique case (TF_ADDR)
				TF_ADDR_FEATURES:  features_q  <= TF_WDATA;
				TF_ADDR_CYL_LOW:   cyl_low_q   <= TF_WDATA;
				TF_ADDR_CYL_HIGH:  cyl_high_q  <= TF_WDATA;
				// device select stays as the host wrote it
				TF_ADDR_DRIVE_SEL: drive_sel_q <= TF_WDATA;
				default: begin
				end
			endcase
		end
	end

	always_comb begin
		state_d = state_q;
		unique case (state_q)
			ST_IDLE: begin
				if (cmd_write) begin
					state_d = ST_CHECK;
				end
			end
			ST_CHECK: begin
				if (fail_cause) begin
					state_d = ST_IDLE;
				end else begin
					state_d = ST_SUM;
				end
			end
			ST_SUM: begin
				if (last_word) begin
					state_d = ST_XFER;
				end
			end
			ST_XFER: begin
				// a new command mid-transfer restarts; the host loses the rest of the structure
				if (cmd_write) begin
					state_d = ST_CHECK;
				end else if (data_read && last_word) begin
					state_d = ST_IDLE;
				end
			end
		endcase
	end

	// opcode of the last command, compared when written so the check cycle only sees the registered result
	always_ff @(posedge REF_CLK) begin
		if (RST) begin
			cmd_ok_q <= 1'b0;
		end else if (cmd_write) begin
			cmd_ok_q <= (TF_WDATA == CMD_HEALTH);
		end
	end

	// state register
	always_ff @(posedge REF_CLK) begin
		if (RST) begin
			state_q <= ST_IDLE;
		end else begin
			state_q <= state_d;
		end
	end

	// error register: cleared by an accepted command, loaded in the check cycle
	always_ff @(posedge REF_CLK) begin
		if (RST) begin
			error_q <= ERROR_RESET;
		end else if (cmd_write) begin
			error_q <= ERROR_RESET;
		end else if (state_q == ST_CHECK) begin
			if (abort_cause) begin
				error_q[ERR_ABORTED_FLAG_BIT] <= 1'b1;
			end else begin
				error_q[ERR_UNC_BIT]  <= DATA_UNCORRECTABLE;
				error_q[ERR_ID_NOT_FOUND_FLAG_BIT] <= ID_NOT_FOUND;
			end
		end
	end

	// busy from the accepted command until completion, good or bad
	always_ff @(posedge REF_CLK) begin
		if (RST) begin
			busy_q <= 1'b0;
		end else if (cmd_write) begin
			busy_q <= 1'b1;
		end else if ((state_q == ST_CHECK) && fail_cause) begin
			// completion: busy low, ready stays high
			busy_q <= 1'b0;
		end else if (sum_done) begin
			// good path: busy drops as the data request rises
			busy_q <= 1'b0;
		end
	end

	// fault stays up until the next accepted command clears it
	always_ff @(posedge REF_CLK) begin
		if (RST) begin
			fault_q <= 1'b0;
		end else if (cmd_write) begin
			fault_q <= 1'b0;
		end else if ((state_q == ST_CHECK) && fail_cause) begin
			fault_q <= 1'b1;
		end
	end

	// data request rises only once the checksum is known, before the first read
	always_ff @(posedge REF_CLK) begin
		if (RST) begin
			drq_q <= 1'b0;
		end else if (cmd_write) begin
			drq_q <= 1'b0;
		end else if ((state_q == ST_CHECK) && fail_cause) begin
			drq_q <= 1'b0;
		end else if (sum_done) begin
			drq_q <= 1'b1;
		end else if (xfer_done) begin
			drq_q <= 1'b0;
		end
	end

	// variable bytes frozen at command start, fixed bytes are constants
	always_ff @(posedge REF_CLK) begin
		if (RST) begin
			offl_snap_q <= 8'h00;
			self_snap_q <= 8'h00;
			secs_snap_q <= 16'h0000;
		end else if (state_q == ST_CHECK) begin
			offl_snap_q <= offl_byte;
			self_snap_q <= SELFTEST_STATUS;
			secs_snap_q <= OFFLINE_SECONDS;
		end
	end

	// word pointer walks all 256 words, once summing, once sending
	always_ff @(posedge REF_CLK) begin
		if (RST) begin
			word_idx_q <= 8'h00;
		end else if (state_q == ST_CHECK) begin
			word_idx_q <= 8'h00;
		end else if ((state_q == ST_SUM) || data_read) begin
			// wraps from 255 to 0, ready for the next pass
			word_idx_q <= 8'(word_idx_q + 8'h01);
		end
	end

	always_comb begin
		status_reg = 8'h00;
		status_reg[STS_BUSY_BIT]  = busy_q;
		// ready never drops: any state takes a new command once busy is low
		status_reg[STS_READY_BIT] = 1'b1;
		status_reg[STS_FAULT_BIT] = fault_q;
		status_reg[STS_DRQ_BIT]   = drq_q;
		status_reg[STS_ERR_BIT]   = |error_q;
	end

	// read data one cycle after the strobe
	always_ff @(posedge REF_CLK) begin
		if (RST) begin
			rdata_q <= 16'h0000;
		end else if (TF_RD) begin
			// a data read outside the transfer returns zero and leaves the pointer alone
			unique case (TF_ADDR)
				// even byte on the low lane
				TF_ADDR_DATA:       rdata_q <= data_read ? {pair_byte[1], pair_byte[0]} : 16'h0000;
				TF_ADDR_FEATURES:   rdata_q <= {8'h00, error_q};
				TF_ADDR_CYL_LOW:    rdata_q <= {8'h00, cyl_low_q};
				TF_ADDR_CYL_HIGH:   rdata_q <= {8'h00, cyl_high_q};
				TF_ADDR_DRIVE_SEL:  rdata_q <= {8'h00, drive_sel_q};
				TF_ADDR_CMD_STATUS: rdata_q <= {8'h00, status_reg};
				default:            rdata_q <= 16'h0000;
			endcase
		end
	end

	assign TF_RDATA = rdata_q;

endmodule

// *** health_data_readout_asserts.sv ***
// port checker for the health data readout block
`timescale 1ns/1ps
module health_data_readout_chk
	import health_pkg::*;
(
	input wire logic        REF_CLK,
	input wire logic        RST,
	input wire logic        TF_WR,
	input wire logic        TF_RD,
	input wire logic [2:0]  TF_ADDR,
	input wire logic [7:0]  TF_WDATA,
	input wire logic [15:0] TF_RDATA,
	input wire logic        SMART_ENABLED
);
	logic dev_q;
	wire  st_rd  = TF_RD && TF_ADDR == TF_ADDR_CMD_STATUS;
	wire  er_rd  = TF_RD && TF_ADDR == TF_ADDR_FEATURES;
	wire  cmd_wr = TF_WR && TF_ADDR == TF_ADDR_CMD_STATUS && TF_WDATA == CMD_HEALTH;
	default clocking @(posedge REF_CLK); endclocking
	default disable iff (RST);
	// assumes drive select is never written while busy
	always_ff @(posedge REF_CLK) begin
		if (RST)
			dev_q <= DRIVE_SEL_RESET[4];
		else if (TF_WR && TF_ADDR == TF_ADDR_DRIVE_SEL)
			dev_q <= TF_WDATA[4];
	end
	a_ready_set: assert property (st_rd |=> TF_RDATA[STS_READY_BIT]) else $error("ready low");
	a_fault_err: assert property (st_rd |=> TF_RDATA[STS_FAULT_BIT] == TF_RDATA[STS_ERR_BIT])
		else $error("fault and error bits differ");
	a_err_no_drq: assert property (st_rd |=> !(TF_RDATA[STS_ERR_BIT] && TF_RDATA[STS_DRQ_BIT]))
		else $error("data request with error");
	a_off_status: assert property (cmd_wr ##1 !SMART_ENABLED ##1 st_rd |=> TF_RDATA == 16'h0061)
		else $error("bad status after abort");
	a_off_code: assert property (cmd_wr ##1 !SMART_ENABLED ##3 er_rd |=> TF_RDATA == 16'h0004)
		else $error("bad error code after abort");
	a_dev_kept: assert property (TF_RD && TF_ADDR == TF_ADDR_DRIVE_SEL |=> TF_RDATA[4] == dev_q)
		else $error("device select lost");
	a_rdata_hold: assert property (!TF_RD |=> $stable(TF_RDATA)) else $error("read data moved");
	a_upper_zero: assert property (TF_RD && TF_ADDR != TF_ADDR_DATA |=> TF_RDATA[15:8] == 8'h00)
		else $error("upper byte set");
endmodule
bind health_data_readout health_data_readout_chk i_chk (
	.REF_CLK       (REF_CLK),
	.RST           (RST),
	.TF_WR         (TF_WR),
	.TF_RD         (TF_RD),
	.TF_ADDR       (TF_ADDR),
	.TF_WDATA      (TF_WDATA),
	.TF_RDATA      (TF_RDATA),
	.SMART_ENABLED (SMART_ENABLED)
);

// *** host_model.sv ***
// host adapter model driving the task-file registers
`timescale 1ns/1ps
module host_model
	import health_pkg::*;
(
	input  wire logic        REF_CLK,
	output logic             TF_WR,
	output logic             TF_RD,
	output logic      [2:0]  TF_ADDR,
	output logic      [7:0]  TF_WDATA,
	input  wire logic [15:0] TF_RDATA
);
	initial begin
		TF_WR = 1'b0;
		TF_RD = 1'b0;
		TF_ADDR = 3'h0;
		TF_WDATA = 8'h00;
	end
	// released data is inverted so a stale value never matches by luck
	task automatic wr(input logic [2:0] a, input logic [7:0] d);
		@(posedge REF_CLK);
		#1;
		TF_WR = 1'b1;
		TF_ADDR = a;
		TF_WDATA = d;
		@(posedge REF_CLK);
		#1;
		TF_WR = 1'b0;
		TF_WDATA = ~d;
	endtask
	task automatic rd(input logic [2:0] a, output logic [15:0] d);
		@(posedge REF_CLK);
		#1;
		TF_RD = 1'b1;
		TF_ADDR = a;
		@(posedge REF_CLK);
		#1;
		TF_RD = 1'b0;
		d = TF_RDATA;
	endtask
	task automatic cmd(input logic [7:0] f, input logic [7:0] lo, input logic [7:0] hi, input logic [7:0] ds);
		logic [15:0] s;
		wr(TF_ADDR_FEATURES, f);
		wr(TF_ADDR_CYL_LOW, lo);
		wr(TF_ADDR_CYL_HIGH, hi);
		wr(TF_ADDR_DRIVE_SEL, ds);
		rd(TF_ADDR_CMD_STATUS, s);
		if (s[STS_READY_BIT] === 1'b1)
			wr(TF_ADDR_CMD_STATUS, CMD_HEALTH);
	endtask
endmodule

// *** health_data_readout_test.sv ***
// self-checking bench for the health data readout block
`timescale 1ns/1ps
module health_data_readout_test;
	import health_pkg::*;
	logic        ref_clk = 1'b0;
	logic        rst = 1'b1;
	logic        sup = 1'b1;
	logic        en = 1'b1;
	logic        uncorrectable_flag = 1'b0;
	logic        id_not_found_flag = 1'b0;
	logic        auto_on = 1'b0;
	logic [2:0]  reason = 3'h0;
	logic [7:0]  st = 8'h00;
	logic [15:0] secs = 16'h0000;
	wire         tf_wr;
	wire         tf_rd;
	wire  [2:0]  tf_addr;
	wire  [7:0]  tf_wdata;
	wire  [15:0] tf_rdata;
	int          err_count = 0;
	int          checked = 0;
	int          cyc = 0;
	logic [15:0] v;
	logic [7:0]  b [512];
	logic [7:0]  s;
	logic [7:0]  oc [5] = '{8'h00, 8'h02, 8'h04, 8'h05, 8'h06};
	// {sup,en,unc,id_not_found_flag} features, key low, key high, expected error
	logic [35:0] ec [8] = '{36'h6D04FC204, 36'h9D04FC204, 36'hCD54FC204, 36'hCD04EC204,
		36'hFD04FC304, 36'hED04FC240, 36'hDD04FC210, 36'hFD04FC250};

	always #10 ref_clk = ~ref_clk;

	health_data_readout i_health_data_readout (
		.REF_CLK            (ref_clk),
		.RST                (rst),
		.TF_WR              (tf_wr),
		.TF_RD              (tf_rd),
		.TF_ADDR            (tf_addr),
		.TF_WDATA           (tf_wdata),
		.TF_RDATA           (tf_rdata),
		.CMD_SUPPORTED      (sup),
		.SMART_ENABLED      (en),
		.DATA_UNCORRECTABLE (uncorrectable_flag),
		.ID_NOT_FOUND       (id_not_found_flag),
		.OFFLINE_REASON     (reason),
		.OFFLINE_AUTO       (auto_on),
		.SELFTEST_STATUS    (st),
		.OFFLINE_SECONDS    (secs)
	);
	host_model i_host_model (
		.REF_CLK  (ref_clk),
		.TF_WR    (tf_wr),
		.TF_RD    (tf_rd),
		.TF_ADDR  (tf_addr),
		.TF_WDATA (tf_wdata),
		.TF_RDATA (tf_rdata)
	);

	task automatic give_verdict;
		$display("errors %0d checks %0d", err_count, checked);
		if (err_count == 0 && checked > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
		checked++;
		if (g !== e) begin
			err_count++;
			$display("ERROR %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic rchk(input logic [2:0] a, input logic [15:0] e, input string n);
		logic [15:0] d;
		i_host_model.rd(a, d);
		chk(n, e, d);
	endtask

	// ceiling is several times the expected run length
	always @(posedge ref_clk) begin
		cyc++;
		if (cyc == 20000) begin
			err_count++;
			give_verdict();
		end
	end

	initial begin
		repeat (3) @(posedge ref_clk);
		#1;
		rst = 1'b0;
		rchk(TF_ADDR_FEATURES, 16'h0000, "error reset");
		rchk(TF_ADDR_CMD_STATUS, 16'h0040, "status reset");
		rchk(TF_ADDR_DRIVE_SEL, 16'h00A0, "drive select reset");
		foreach (ec[i]) begin
			{sup, en, uncorrectable_flag, id_not_found_flag} = ec[i][35:32];
			i_host_model.cmd(ec[i][31:24], ec[i][23:16], ec[i][15:8], i[0] ? 8'hB0 : 8'hA0);
			rchk(TF_ADDR_CMD_STATUS, 16'h0061, "error status");
			rchk(TF_ADDR_FEATURES, 16'(ec[i][7:0]), "error flags");
			rchk(TF_ADDR_DRIVE_SEL, i[0] ? 16'h00B0 : 16'h00A0, "drive select");
		end
		{sup, en, uncorrectable_flag, id_not_found_flag} = 4'hC;
		// keys still valid from the last error case, only the opcode is wrong
		i_host_model.wr(TF_ADDR_CMD_STATUS, 8'hEF);
		rchk(TF_ADDR_CMD_STATUS, 16'h0061, "bad opcode status");
		rchk(TF_ADDR_FEATURES, 16'h0004, "bad opcode flags");
		for (int r = 0; r < 5; r++) begin
			reason = 3'(r);
			auto_on = reason[0];
			st = 8'(8'h11 * r);
			secs = 16'(16'h1234 + 16'h0101 * r);
			i_host_model.cmd(FEAT_READ_DATA, KEY_CYL_LOW, KEY_CYL_HIGH, 8'hA0);
			v = 16'h0000;
			for (int i = 0; i < 300 && v[STS_DRQ_BIT] !== 1'b1; i++)
				i_host_model.rd(TF_ADDR_CMD_STATUS, v);
			chk("ready status", 16'h0048, v);
			for (int k = 0; k < 256; k++) begin
				i_host_model.rd(TF_ADDR_DATA, v);
				{b[2*k+1], b[2*k]} = v;
			end
			rchk(TF_ADDR_CMD_STATUS, 16'h0040, "status after 512 bytes");
			s = 8'h00;
			foreach (b[i])
				s += b[i];
			chk("byte sum", 16'h0000, 16'(s));
			chk("offline status", 16'(oc[r] | {auto_on, 7'h00}), 16'(b[362]));
			chk("selftest", 16'(st), 16'(b[363]));
			chk("seconds", secs, {b[365], b[364]});
			chk("offline cap", 16'(OFFLINE_CAP_VAL), 16'(b[367]));
			chk("smart cap", SMART_CAP_VAL, {b[369], b[368]});
			chk("errlog cap", 16'(ERRLOG_SUPPORTED), 16'(b[370]));
			chk("poll short", 16'(POLL_SHORT_MIN), 16'(b[372]));
			chk("poll ext", 16'(POLL_EXT_MIN), 16'(b[373]));
			for (int i = 374; i <= 385; i++)
				chk("reserved", 16'h0000, 16'(b[i]));
		end
		give_verdict();
	end
endmodule
